// >>> src/pkt_auto_pkg.sv
// Constants and types for the packet handler automatic-mode control
// Contract
// - An 8-bit node id register is read/write and matched against rx address.
// - An 8-bit group id register, reset zero, is a second accepted address.
// - Entry trigger bits 7-5 pick the event that enters the interim mode.
// - Leave trigger bits 4-2 pick the event that leaves the interim mode.
// - Interim state bits 1-0 pick the mode entered, reset sleep.
// - Send trigger bit 7 (reset 1) picks queue nonempty or level to send.
// - A 7-bit queue level limit (reset 0x0f) drives the queue level flag.
// - The frame gap is 2^setting bit periods, or zero for settings of 12+.
// - Writing one to restart bit 2 restarts the receiver; it reads zero.
// - Auto restart (reset 1) restarts rx after frame, readout and gap.
// - Cipher enable bit 0 (reset 0) turns on cipher and limits length 66.
// - A write-only register holds key bits 127:120, reset zero.
// - Filter mode 01 accepts node id only; 10 also accepts group id.
package pkt_auto_pkg;
  localparam int AW = 12;
  localparam logic [7:0] IDX_NODE_ID = 8'h39;
  localparam logic [7:0] IDX_GROUP_ID = 8'h3a;
  localparam logic [7:0] IDX_AUTO_SEQ = 8'h3b;
  localparam logic [7:0] IDX_QUEUE_LIM = 8'h3c;
  localparam logic [7:0] IDX_FRAME_CTRL2 = 8'h3d;
  localparam logic [7:0] IDX_KEY_TOP = 8'h3e;
  localparam logic [7:0] IDX_MODE_CTRL = 8'h60;
  localparam logic [7:0] IDX_STATUS = 8'h61;
  localparam logic [7:0] RST_NODE_ID = 8'h00;
  localparam logic [7:0] RST_GROUP_ID = 8'h00;
  localparam logic [7:0] RST_AUTO_SEQ = 8'h00;
  localparam logic [7:0] RST_QUEUE_LIM = 8'h8f;
  localparam logic [7:0] RST_FRAME_CTRL2 = 8'h02;
  localparam logic [7:0] RST_KEY_TOP = 8'h00;
  localparam logic [7:0] RST_MODE_CTRL = 8'h01;
  localparam logic [7:0] FC2_WMASK = 8'hfb;
  localparam int ENTRY_LSB = 5;
  localparam int LEAVE_LSB = 2;
  localparam int INTERIM_LSB = 0;
  localparam int SEND_TRIG_BIT = 7;
  localparam int GAP_LSB = 4;
  localparam int RESTART_BIT = 2;
  localparam int AUTO_RESTART_BIT = 1;
  localparam int CIPHER_BIT = 0;
  localparam int SWMODE_LSB = 0;
  localparam int FILTER_LSB = 2;
  localparam logic [2:0] TRIG_OFF = 3'h0;
  localparam logic [1:0] MODE_SLEEP = 2'h0;
  localparam logic [1:0] FILT_NODE = 2'h1;
  localparam logic [1:0] FILT_GROUP = 2'h2;
  localparam logic [3:0] GAP_ZERO_MIN = 4'hc;
  localparam logic [7:0] CIPHER_MAX_LEN = 8'h42;
  localparam logic [7:0] PLAIN_MAX_LEN = 8'hff;
  localparam int NFLAGS = 7;
  localparam int FL_NONEMPTY = 0;
  localparam int FL_LEVEL = 1;
  localparam int FL_CHECK = 2;
  localparam int FL_RECV = 3;
  localparam int FL_PREAMBLE = 4;
  localparam int FL_SENT = 5;
  localparam int FL_TIMEOUT = 6;
  typedef enum logic [0:0] {SEQ_HOME, SEQ_INTERIM} seq_state_t;

  function automatic logic [AW-1:0] byte_addr(input logic [7:0] idx);
    return {2'b00, idx, 2'b00};
  endfunction : byte_addr
endpackage : pkt_auto_pkg

// >>> src/flag_edges.sv
// Rising and falling edge pulses of the packet engine flags
`timescale 1ns/10ps
module flag_edges (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Flags in, edge pulses out
  input wire logic [pkt_auto_pkg::NFLAGS-1:0] flags,
  output logic [pkt_auto_pkg::NFLAGS-1:0] rise,
  output logic [pkt_auto_pkg::NFLAGS-1:0] fall
);
  import pkt_auto_pkg::*;
  typedef struct packed {
    logic [NFLAGS-1:0] prev;
  } edge_st_t;
  edge_st_t s_q, s_d;

  always_comb
  begin
    s_d = s_q;
    s_d.prev = flags;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign rise = flags & ~s_q.prev;
  assign fall = ~flags & s_q.prev;

  property p_edge_single;
    @(posedge pclk) disable iff (!presetn)
      (rise != '0) |=> ((rise & $past(rise)) == '0);
  endproperty
  a_edge_single: assert property (p_edge_single)
    else $error("edge pulse lasted more than one cycle");
endmodule : flag_edges

// >>> src/frame_gap_timer.sv
// Frame gap timer counting bit periods before a receiver restart
`timescale 1ns/10ps
module frame_gap_timer (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control
  input wire logic start,
  input wire logic abort,
  input wire logic [3:0] setting,
  input wire logic bit_tick,
  // Result
  output logic done,
  output logic busy
);
  import pkt_auto_pkg::*;
  typedef struct packed {
    logic busy;
    logic done;
    logic [11:0] cnt;
    logic [3:0] sel;
  } gap_st_t;
  gap_st_t s_q, s_d;

  always_comb
  begin
    s_d = s_q;
    s_d.done = 1'b0;
    if (abort)
      s_d.busy = 1'b0;
    else if (start)
    begin
      if (setting >= GAP_ZERO_MIN)
        s_d.done = 1'b1;
      else
      begin
        s_d.busy = 1'b1;
        s_d.cnt = '0;
        s_d.sel = setting;
      end
    end
    else if (s_q.busy && bit_tick)
    begin
      if (s_q.cnt == (12'h001 << s_q.sel) - 12'h001)
      begin
        s_d.busy = 1'b0;
        s_d.done = 1'b1;
      end
      else
        s_d.cnt = s_q.cnt + 12'h001;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign done = s_q.done;
  assign busy = s_q.busy;

  property p_gap_cause;
    @(posedge pclk) disable iff (!presetn)
      done |-> ($past(busy) && !$past(abort))
        || ($past(start) && $past(setting) >= GAP_ZERO_MIN);
  endproperty
  a_gap_cause: assert property (p_gap_cause)
    else $error("gap done without elapsed gap");
endmodule : frame_gap_timer

// >>> src/pkt_auto_ctrl.sv
// Packet handler automatic-mode control with APB register access
//
// Chosen here: register access over APB.
`timescale 1ns/10ps
module pkt_auto_ctrl (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [pkt_auto_pkg::AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Packet engine flags, same clock
  input wire logic queue_nonempty_flag,
  input wire logic [6:0] queue_fill_count,
  input wire logic check_pass_flag,
  input wire logic frame_received_flag,
  input wire logic preamble_match_flag,
  input wire logic frame_sent_flag,
  input wire logic timeout_flag,
  input wire logic bit_tick,
  // Receive address filter
  input wire logic rx_addr_valid,
  input wire logic [7:0] rx_addr_byte,
  output logic addr_check_done,
  output logic addr_accept,
  // Control outputs
  output logic [1:0] op_mode,
  output logic tx_start,
  output logic queue_level_flag,
  output logic receiver_restart,
  output logic cipher_enable,
  output logic [7:0] cipher_key_top,
  output logic [7:0] max_payload_len
);
  import pkt_auto_pkg::*;

  typedef struct packed {
    logic [7:0] node_id;
    logic [7:0] group_id;
    logic [7:0] auto_seq;
    logic [7:0] queue_lim;
    logic [7:0] frame_ctrl;
    logic [7:0] key_top;
    logic [7:0] mode_ctrl;
    seq_state_t seq;
    logic [1:0] op_mode;
    logic level;
    logic tx_start;
    logic restart;
    logic rx_pend;
    logic addr_done;
    logic addr_ok;
    logic [7:0] max_len;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } top_st_t;

  localparam top_st_t ST_RESET = '{
    node_id: RST_NODE_ID, group_id: RST_GROUP_ID,
    auto_seq: RST_AUTO_SEQ, queue_lim: RST_QUEUE_LIM,
    frame_ctrl: RST_FRAME_CTRL2, key_top: RST_KEY_TOP,
    mode_ctrl: RST_MODE_CTRL, seq: SEQ_HOME,
    op_mode: RST_MODE_CTRL[SWMODE_LSB +: 2], level: 1'b0,
    tx_start: 1'b0, restart: 1'b0, rx_pend: 1'b0,
    addr_done: 1'b0, addr_ok: 1'b0, max_len: PLAIN_MAX_LEN,
    prdata: 32'h0000_0000, pready: 1'b0, pslverr: 1'b0};

  top_st_t s_q, s_d;
  logic [NFLAGS-1:0] flags, rise, fall;
  logic setup, access, wr, man_restart;
  logic [2:0] entry_code, leave_code;
  logic [1:0] interim_sel, sw_mode, filt;
  logic auto_on, auto_en, entry_ev, leave_ev;
  logic gap_start, gap_done, gap_busy;

  // Entry event for each trigger code
  function automatic logic entry_hit(input logic [2:0] c,
    input logic [NFLAGS-1:0] r, input logic [NFLAGS-1:0] f);
    case (c)
      3'h1: entry_hit = r[FL_NONEMPTY];
      3'h2: entry_hit = r[FL_LEVEL];
      3'h3: entry_hit = r[FL_CHECK];
      3'h4: entry_hit = r[FL_RECV];
      3'h5: entry_hit = r[FL_PREAMBLE];
      3'h6: entry_hit = r[FL_SENT];
      3'h7: entry_hit = f[FL_NONEMPTY];
      default: entry_hit = 1'b0;
    endcase
  endfunction : entry_hit

  // Leave event for each trigger code
  function automatic logic leave_hit(input logic [2:0] c,
    input logic [NFLAGS-1:0] r, input logic [NFLAGS-1:0] f);
    case (c)
      3'h1: leave_hit = f[FL_NONEMPTY];
      3'h2: leave_hit = r[FL_LEVEL] | r[FL_TIMEOUT];
      3'h3: leave_hit = r[FL_CHECK] | r[FL_TIMEOUT];
      3'h4: leave_hit = r[FL_RECV] | r[FL_TIMEOUT];
      3'h5: leave_hit = r[FL_PREAMBLE] | r[FL_TIMEOUT];
      3'h6: leave_hit = r[FL_SENT];
      3'h7: leave_hit = r[FL_TIMEOUT];
      default: leave_hit = 1'b0;
    endcase
  endfunction : leave_hit

  assign flags = {timeout_flag, frame_sent_flag, preamble_match_flag,
    frame_received_flag, check_pass_flag, s_q.level,
    queue_nonempty_flag};

  flag_edges u_edges (
    .pclk(pclk),
    .presetn(presetn),
    .flags(flags),
    .rise(rise),
    .fall(fall)
  );

  assign setup = psel & ~penable;
  assign access = psel & penable & s_q.pready;
  assign wr = access & pwrite;
  assign man_restart = wr & (paddr == byte_addr(IDX_FRAME_CTRL2))
    & pwdata[RESTART_BIT];
  assign entry_code = s_q.auto_seq[ENTRY_LSB +: 3];
  assign leave_code = s_q.auto_seq[LEAVE_LSB +: 3];
  assign interim_sel = s_q.auto_seq[INTERIM_LSB +: 2];
  assign sw_mode = s_q.mode_ctrl[SWMODE_LSB +: 2];
  assign filt = s_q.mode_ctrl[FILTER_LSB +: 2];
  // Either code at zero switches the sequencer off
  assign auto_on = (entry_code != TRIG_OFF) && (leave_code != TRIG_OFF);
  assign entry_ev = entry_hit(entry_code, rise, fall);
  assign leave_ev = leave_hit(leave_code, rise, fall);
  assign auto_en = s_q.frame_ctrl[AUTO_RESTART_BIT];
  // Gap waits for the frame to be fully read out
  assign gap_start = s_q.rx_pend & ~queue_nonempty_flag & auto_en;

  frame_gap_timer u_gap (
    .pclk(pclk),
    .presetn(presetn),
    .start(gap_start),
    .abort(man_restart),
    .setting(s_q.frame_ctrl[GAP_LSB +: 4]),
    .bit_tick(bit_tick),
    .done(gap_done),
    .busy(gap_busy)
  );

  always_comb
  begin
    logic [7:0] rd;
    logic hit;
    rd = 8'h00;
    hit = 1'b1;
    s_d = s_q;
    s_d.pready = setup;
    s_d.pslverr = 1'b0;
    s_d.restart = 1'b0;
    s_d.addr_done = 1'b0;
    // Read data prepared in setup so every output stays a flop
    if (paddr == byte_addr(IDX_NODE_ID))
      rd = s_q.node_id;
    else if (paddr == byte_addr(IDX_GROUP_ID))
      rd = s_q.group_id;
    else if (paddr == byte_addr(IDX_AUTO_SEQ))
      rd = s_q.auto_seq;
    else if (paddr == byte_addr(IDX_QUEUE_LIM))
      rd = s_q.queue_lim;
    else if (paddr == byte_addr(IDX_FRAME_CTRL2))
      rd = s_q.frame_ctrl;
    else if (paddr == byte_addr(IDX_KEY_TOP))
      rd = 8'h00;
    else if (paddr == byte_addr(IDX_MODE_CTRL))
      rd = s_q.mode_ctrl;
    else if (paddr == byte_addr(IDX_STATUS))
      rd = {1'b0, s_q.rx_pend, gap_busy, s_q.tx_start, s_q.level,
        s_q.seq == SEQ_INTERIM, s_q.op_mode};
    else
      hit = 1'b0;
    if (setup)
    begin
      s_d.prdata = {24'h00_0000, rd};
      s_d.pslverr = ~hit;
    end
    // Writes land only on the completing access edge
    if (wr)
    begin
      if (paddr == byte_addr(IDX_NODE_ID))
        s_d.node_id = pwdata[7:0];
      else if (paddr == byte_addr(IDX_GROUP_ID))
        s_d.group_id = pwdata[7:0];
      else if (paddr == byte_addr(IDX_AUTO_SEQ))
        s_d.auto_seq = pwdata[7:0];
      else if (paddr == byte_addr(IDX_QUEUE_LIM))
        s_d.queue_lim = pwdata[7:0];
      else if (paddr == byte_addr(IDX_FRAME_CTRL2))
        s_d.frame_ctrl = pwdata[7:0] & FC2_WMASK;
      else if (paddr == byte_addr(IDX_KEY_TOP))
        s_d.key_top = pwdata[7:0];
      else if (paddr == byte_addr(IDX_MODE_CTRL))
        s_d.mode_ctrl = pwdata[7:0];
    end
    // Interim mode sequencer
    case (s_q.seq)
      SEQ_HOME:
        if (auto_on && entry_ev)
          s_d.seq = SEQ_INTERIM;
      SEQ_INTERIM:
        if (!auto_on || leave_ev)
          s_d.seq = SEQ_HOME;
      default:
        s_d.seq = SEQ_HOME;
    endcase
    s_d.op_mode = (s_d.seq == SEQ_INTERIM) ? interim_sel : sw_mode;
    s_d.level = queue_fill_count > s_q.queue_lim[6:0];
    s_d.tx_start = s_q.queue_lim[SEND_TRIG_BIT] ? queue_nonempty_flag
      : s_q.level;
    // Set wins over the clear when both land together
    s_d.rx_pend = auto_en & ((rise[FL_RECV]) | (s_q.rx_pend & ~gap_start));
    s_d.restart = man_restart | (gap_done & auto_en);
    if (rx_addr_valid)
    begin
      s_d.addr_done = 1'b1;
      if (filt == FILT_GROUP)
        s_d.addr_ok = (rx_addr_byte == s_q.node_id)
          || (rx_addr_byte == s_q.group_id);
      else if (filt == FILT_NODE || filt == 2'h3)
        s_d.addr_ok = rx_addr_byte == s_q.node_id;
      else
        s_d.addr_ok = 1'b1;
    end
    // Next value so the limit moves in step with cipher_enable
    s_d.max_len = s_d.frame_ctrl[CIPHER_BIT] ? CIPHER_MAX_LEN
      : PLAIN_MAX_LEN;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      s_q <= ST_RESET;
    else
      s_q <= s_d;
  end

  assign prdata = s_q.prdata;
  assign pready = s_q.pready;
  assign pslverr = s_q.pslverr;
  assign addr_check_done = s_q.addr_done;
  assign addr_accept = s_q.addr_ok;
  assign op_mode = s_q.op_mode;
  assign tx_start = s_q.tx_start;
  assign queue_level_flag = s_q.level;
  assign receiver_restart = s_q.restart;
  assign cipher_enable = s_q.frame_ctrl[CIPHER_BIT];
  assign cipher_key_top = s_q.key_top;
  assign max_payload_len = s_q.max_len;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  property p_node_match;
    rx_addr_valid && filt == FILT_NODE |=> addr_check_done
      && addr_accept == ($past(rx_addr_byte) == $past(s_q.node_id));
  endproperty
  a_node_match: assert property (p_node_match)
    else $error("node filter result wrong");

  property p_group_match;
    rx_addr_valid && filt == FILT_GROUP && rx_addr_byte == s_q.group_id
      |=> addr_accept;
  endproperty
  a_group_match: assert property (p_group_match)
    else $error("group address rejected");

  property p_enter;
    s_q.seq == SEQ_HOME && auto_on && entry_ev
      |=> s_q.seq == SEQ_INTERIM && op_mode == $past(interim_sel);
  endproperty
  a_enter: assert property (p_enter)
    else $error("interim mode not entered");

  property p_off_stays;
    entry_code == TRIG_OFF |=> s_q.seq == SEQ_HOME;
  endproperty
  a_off_stays: assert property (p_off_stays)
    else $error("sequencer active while off");

  property p_leave;
    s_q.seq == SEQ_INTERIM && leave_ev |=> op_mode == $past(sw_mode);
  endproperty
  a_leave: assert property (p_leave)
    else $error("mode not restored on leave");

  property p_reset_interim;
    $rose(presetn) |-> s_q.auto_seq[INTERIM_LSB +: 2] == MODE_SLEEP;
  endproperty
  a_reset_interim: assert property (p_reset_interim)
    else $error("interim field reset wrong");

  property p_level_send;
    !s_q.queue_lim[SEND_TRIG_BIT] && queue_fill_count > s_q.queue_lim[6:0]
      ##1 !s_q.queue_lim[SEND_TRIG_BIT] |=> tx_start;
  endproperty
  a_level_send: assert property (p_level_send)
    else $error("send not started above limit");

  property p_level_low;
    queue_fill_count <= s_q.queue_lim[6:0] |=> !queue_level_flag;
  endproperty
  a_level_low: assert property (p_level_low)
    else $error("level flag set at or below limit");

  property p_manual_restart;
    man_restart |=> receiver_restart && !s_q.frame_ctrl[RESTART_BIT];
  endproperty
  a_manual_restart: assert property (p_manual_restart)
    else $error("manual restart missing or bit stuck");

  property p_auto_restart;
    gap_done && auto_en |=> receiver_restart;
  endproperty
  a_auto_restart: assert property (p_auto_restart)
    else $error("auto restart missing after gap");

  property p_cipher_len;
    cipher_enable |-> max_payload_len == CIPHER_MAX_LEN;
  endproperty
  a_cipher_len: assert property (p_cipher_len)
    else $error("cipher length limit wrong");

  property p_key_reads_zero;
    setup && paddr == byte_addr(IDX_KEY_TOP) |=> prdata == 32'h0000_0000;
  endproperty
  a_key_reads_zero: assert property (p_key_reads_zero)
    else $error("key register readable");

  property p_c_interim;
    s_q.seq == SEQ_HOME ##1 s_q.seq == SEQ_INTERIM;
  endproperty
  c_interim: cover property (p_c_interim);

  property p_c_restart;
    gap_start ##[1:300] receiver_restart;
  endproperty
  c_restart: cover property (p_c_restart);

  property p_c_accept;
    addr_check_done && addr_accept && filt == FILT_GROUP;
  endproperty
  c_accept: cover property (p_c_accept);
endmodule : pkt_auto_ctrl

// >>> tb/pkt_auto_ctrl_tb.sv
// Self-checking testbench for the packet handler automatic-mode control
`timescale 1ns/10ps
module pkt_auto_ctrl_tb;
  import pkt_auto_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, bit_tick, rx_v;
  logic [AW-1:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, err, done_o, accept_o, tx_start, level_o;
  logic restart_o, cipher_o;
  logic [1:0] op_mode;
  logic [7:0] key_o, maxlen_o, rx_b;
  logic [6:0] fl, fill;
  int n_errors, n_tests;

  pkt_auto_ctrl i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr),
    .queue_nonempty_flag(fl[FL_NONEMPTY]), .queue_fill_count(fill),
    .check_pass_flag(fl[FL_CHECK]), .frame_received_flag(fl[FL_RECV]),
    .preamble_match_flag(fl[FL_PREAMBLE]), .frame_sent_flag(fl[FL_SENT]),
    .timeout_flag(fl[FL_TIMEOUT]), .bit_tick(bit_tick),
    .rx_addr_valid(rx_v), .rx_addr_byte(rx_b),
    .addr_check_done(done_o), .addr_accept(accept_o), .op_mode(op_mode),
    .tx_start(tx_start), .queue_level_flag(level_o),
    .receiver_restart(restart_o), .cipher_enable(cipher_o),
    .cipher_key_top(key_o), .max_payload_len(maxlen_o)
  );

  initial
  begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic test_done;
    if (n_errors == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : test_done

  // Data and error are taken at the edge that samples pready high
  task automatic apb(input logic w, input logic [7:0] idx,
                     input logic [7:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1)
    begin
      n_errors++;
      test_done();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d);
  endtask : wr

  task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00);
    chk(rd, {24'h0, exp});
    chk({31'h0, err}, 32'h0);
  endtask : rdc

  task automatic cyc(input int n);
    repeat (n) @(negedge pclk);
  endtask : cyc

  task automatic t_regs;
    rdc(IDX_NODE_ID, 8'h00);
    rdc(IDX_GROUP_ID, 8'h00);
    rdc(IDX_AUTO_SEQ, 8'h00);
    rdc(IDX_QUEUE_LIM, 8'h8f);
    rdc(IDX_FRAME_CTRL2, 8'h02);
    rdc(IDX_MODE_CTRL, 8'h01);
    rdc(IDX_STATUS, 8'h01);
    chk({24'h0, maxlen_o}, 32'hff);
    wr(IDX_NODE_ID, 8'h5a);
    rdc(IDX_NODE_ID, 8'h5a);
    wr(IDX_GROUP_ID, 8'ha5);
    rdc(IDX_GROUP_ID, 8'ha5);
    wr(IDX_KEY_TOP, 8'hc3);
    rdc(IDX_KEY_TOP, 8'h00);
    chk({24'h0, key_o}, 32'hc3);
    wr(IDX_FRAME_CTRL2, 8'h03);
    cyc(2);
    chk({31'h0, cipher_o}, 32'h1);
    chk({24'h0, maxlen_o}, 32'h42);
    wr(IDX_FRAME_CTRL2, 8'h02);
    cyc(2);
    chk({24'h0, maxlen_o}, 32'hff);
    apb(1'b0, 8'h50, 8'h00);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
  endtask : t_regs

  // Checks how many ticks had been issued when the restart pulse came against exp (-1 if none)
  task automatic gap_run(input int exp);
    int t;
    int seen;
    t = 0;
    seen = -1;
    for (int i = 0; i < 48; i++)
    begin
      @(posedge pclk);
      bit_tick <= (i % 4 == 3);
      if (i % 4 == 3)
        t++;
      @(negedge pclk);
      if (restart_o === 1'b1 && seen < 0)
        seen = t;
    end
    @(posedge pclk);
    bit_tick <= 1'b0;
    chk(seen, exp);
  endtask : gap_run

  task automatic rise(input int k);
    @(posedge pclk);
    fl[k] <= 1'b0;
    @(posedge pclk);
    fl[k] <= 1'b1;
  endtask : rise

  task automatic t_restart;
    wr(IDX_FRAME_CTRL2, 8'h06);
    cyc(1);
    chk({31'h0, restart_o}, 32'h1);
    cyc(1);
    chk({31'h0, restart_o}, 32'h0);
    rdc(IDX_FRAME_CTRL2, 8'h02);
    wr(IDX_FRAME_CTRL2, 8'h12);
    rise(FL_RECV);
    gap_run(2);
    wr(IDX_FRAME_CTRL2, 8'h10);
    rise(FL_RECV);
    gap_run(-1);
    wr(IDX_FRAME_CTRL2, 8'hc2);
    rise(FL_RECV);
    gap_run(0);
  endtask : t_restart

  task automatic t_level;
    wr(IDX_QUEUE_LIM, 8'h05);
    @(posedge pclk) fill <= 7'd5;
    cyc(3);
    chk({31'h0, level_o}, 32'h0);
    chk({31'h0, tx_start}, 32'h0);
    @(posedge pclk) fill <= 7'd6;
    cyc(3);
    chk({31'h0, level_o}, 32'h1);
    chk({31'h0, tx_start}, 32'h1);
    @(posedge pclk) fill <= 7'd0;
    wr(IDX_QUEUE_LIM, 8'h85);
    @(posedge pclk) fl[FL_NONEMPTY] <= 1'b1;
    cyc(3);
    chk({31'h0, tx_start}, 32'h1);
    chk({31'h0, level_o}, 32'h0);
    @(posedge pclk) fl[FL_NONEMPTY] <= 1'b0;
    cyc(3);
    chk({31'h0, tx_start}, 32'h0);
  endtask : t_level

  task automatic t_auto;
    @(posedge pclk) fl <= 7'h00;
    wr(IDX_MODE_CTRL, 8'h01);
    wr(IDX_AUTO_SEQ, 8'h26);
    @(posedge pclk) fl[FL_NONEMPTY] <= 1'b1;
    cyc(2);
    chk({30'h0, op_mode}, 32'h2);
    @(posedge pclk) fl[FL_NONEMPTY] <= 1'b0;
    cyc(2);
    chk({30'h0, op_mode}, 32'h1);
    // Entry codes 011..110 against flags check..sent, leave on timeout
    for (int i = 0; i < 4; i++)
    begin
      wr(IDX_AUTO_SEQ, {3'(i + 3), 3'b111, 2'b11});
      @(posedge pclk) fl[i + FL_CHECK] <= 1'b1;
      cyc(2);
      chk({30'h0, op_mode}, 32'h3);
      @(posedge pclk) fl[FL_TIMEOUT] <= 1'b1;
      cyc(2);
      chk({30'h0, op_mode}, 32'h1);
      @(posedge pclk) fl <= 7'h00;
    end
    wr(IDX_AUTO_SEQ, 8'h03);
    @(posedge pclk) fl[FL_NONEMPTY] <= 1'b1;
    cyc(3);
    chk({30'h0, op_mode}, 32'h1);
    @(posedge pclk) fl[FL_NONEMPTY] <= 1'b0;
  endtask : t_auto

  // Entry on queue going empty; leave codes 010..110 by their flags
  task automatic t_auto_alt;
    for (int i = 0; i < 5; i++)
    begin
      wr(IDX_AUTO_SEQ, {3'b111, 3'(i + 2), 2'b10});
      @(posedge pclk) fl[FL_NONEMPTY] <= 1'b1;
      @(posedge pclk) fl[FL_NONEMPTY] <= 1'b0;
      cyc(2);
      chk({30'h0, op_mode}, 32'h2);
      @(posedge pclk);
      if (i == 0)
        fill <= 7'd6;
      else
        fl[i + 1] <= 1'b1;
      // Level flag is registered, so its edge comes a cycle later
      cyc(3);
      chk({30'h0, op_mode}, 32'h1);
      @(posedge pclk) fl <= 7'h00;
      fill <= 7'd0;
    end
    // Entry on level rise, leave on timeout
    wr(IDX_AUTO_SEQ, 8'h5f);
    @(posedge pclk) fill <= 7'd6;
    cyc(3);
    chk({30'h0, op_mode}, 32'h3);
    @(posedge pclk) fl[FL_TIMEOUT] <= 1'b1;
    cyc(2);
    chk({30'h0, op_mode}, 32'h1);
    @(posedge pclk) fl <= 7'h00;
    fill <= 7'd0;
    wr(IDX_AUTO_SEQ, 8'h00);
  endtask : t_auto_alt

  task automatic filt(input logic [7:0] b, input logic exp);
    @(posedge pclk);
    rx_v <= 1'b1;
    rx_b <= b;
    @(posedge pclk) rx_v <= 1'b0;
    @(negedge pclk);
    chk({31'h0, done_o}, 32'h1);
    chk({31'h0, accept_o}, {31'h0, exp});
  endtask : filt

  task automatic t_filter;
    wr(IDX_MODE_CTRL, 8'h05);
    filt(8'h5a, 1'b1);
    filt(8'ha5, 1'b0);
    wr(IDX_MODE_CTRL, 8'h09);
    filt(8'ha5, 1'b1);
    filt(8'h33, 1'b0);
    wr(IDX_MODE_CTRL, 8'h01);
    filt(8'h33, 1'b1);
    wr(IDX_MODE_CTRL, 8'h0d);
    filt(8'ha5, 1'b0);
    filt(8'h5a, 1'b1);
  endtask : t_filter

  // Hang guard
  initial
  begin
    repeat (100000) @(posedge pclk);
    n_errors++;
    test_done();
  end

  initial
  begin
    presetn = 1'b0;
    {psel, penable, pwrite, bit_tick, rx_v} = 5'h00;
    paddr = '0;
    pwdata = 32'h0;
    rx_b = 8'h00;
    fl = 7'h00;
    fill = 7'h00;
    n_errors = 0;
    n_tests = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_restart();
    t_level();
    t_auto();
    t_auto_alt();
    t_filter();
    test_done();
  end
endmodule : pkt_auto_ctrl_tb
